// File: hdl/rsi_defs.svh
`ifndef RSI_DEFS_SVH
`define RSI_DEFS_SVH

// Word indexes; byte address is four times the index
`define RSI_IDX_PLATCH   0
`define RSI_IDX_DIR      6
`define RSI_IDX_PULL     11
`define RSI_IDX_P6IN     14
`define RSI_IDX_P6OUT    15
`define RSI_IDX_ALT      16
`define RSI_IDX_MEMSZ    17
`define RSI_IDX_CLKMODE  18
`define RSI_IDX_CPUCLK   19
`define RSI_IDX_OSCPLL   20
`define RSI_IDX_MAINOSC  21
`define RSI_IDX_MAINCLK  22
`define RSI_IDX_OSCSTAT  23
`define RSI_IDX_OSCSEL   24
`define RSI_IDX_TXCTL    25
`define RSI_IDX_TXIOC    34
`define RSI_IDX_TXCMP    36
`define RSI_IDX_TXCC     44
`define RSI_IDX_HIZ      46
`define RSI_IDX_EC16     49
`define RSI_IDX_EC16A    50
`define RSI_IDX_EC16B    51
`define RSI_IDX_EC16CTL  52
`define RSI_IDX_EC8      56
`define RSI_IDX_IT8      60
`define RSI_IDX_WDT      64
`define RSI_IDX_STAT     65
`define RSI_IDX_PC       66
`define RSI_NSFR         65
`define RSI_NREG         67

// Reset values
`define RSI_RV_ZERO      16'h0000
`define RSI_RV_DIR       16'h00ff
`define RSI_RV_MEMSZ     16'h00cf
`define RSI_RV_CPUCLK    16'h0001
`define RSI_RV_OSCPLL    16'h0080
`define RSI_RV_MAINOSC   16'h0080
`define RSI_RV_OSCSEL    16'h0005
`define RSI_RV_WDT       16'h001a
`define RSI_WDT_OPT_BIT  7

// Memory size codes software writes after release
`define RSI_MEMSZ_4K     8'h61
`define RSI_MEMSZ_8K     8'h42
`define RSI_MEMSZ_16K    8'h04

// Reset vector addresses
`define RSI_VEC_LO       16'h0000
`define RSI_VEC_HI       16'h0001

// Status word bit positions
`define RSI_STAT_PCV     0
`define RSI_STAT_RUN     1
`define RSI_STAT_WDOPT   2

// Settle wait is this many cycles shifted left by the select code
`define RSI_SETTLE_UNIT  16

`endif

// File: hdl/rsi_pkg.sv
package rsi_pkg;

  typedef enum logic [2:0] {
    ST_HOLD   = 3'b000,
    ST_SETTLE = 3'b001,
    ST_ACK    = 3'b010,
    ST_VEC_LO = 3'b011,
    ST_VEC_HI = 3'b100,
    ST_VEC_LD = 3'b101,
    ST_RUN    = 3'b110
  } rsi_state_t;

  typedef struct packed {
    logic [7:0] memory_size_select;
    logic [7:0] clk_mode;
    logic [7:0] cpu_clk;
    logic [7:0] internal_osc_pll_control;
    logic [7:0] main_osc_control;
    logic [7:0] main_clock_mode;
    logic [7:0] osc_settle_time_select;
    logic [7:0] watchdog_enable_reg;
  } rsi_clk_cfg_t;

  typedef struct packed {
    logic [5:0][7:0] latch;
    logic [4:0][7:0] direction;
    logic [2:0][7:0] pullup_enable;
    logic [7:0]      port6_input_mode;
    logic [7:0]      port6_output_mode;
    logic [7:0]      alt_switch;
  } rsi_port_cfg_t;

endpackage

// File: hdl/rsi_reset_state_init.sv
`timescale 1ns/1ps
`include "rsi_defs.svh"
// Summary of operation
// - PC loaded from vector bytes 0000, 0001
// - During reset/settle only PC undefined
// - RAM and register banks never initialised
// - Port output latches cleared to zero
// - Port direction registers set to inputs
// - Pull-ups, port6 modes, alt switch cleared
// - Memory size select defaults to CF
// - Clock operation mode register cleared
// - Processor clock control defaults to 01
// - Internal oscillator/PLL control defaults 80
// - Main oscillator control 80, crystal stopped
// - Main clock mode, settle status cleared
// - Settle time select defaults to 05
// - Timer X control registers cleared
// - Timer X compare, capture registers cleared
// - High-impedance output registers cleared
// - 16-bit event counter registers cleared
// - 8-bit event counter registers cleared
// - 8-bit interval timer registers cleared
// - Watchdog enable defaults 1A or 9A
// - Option byte picks watchdog default
module rsi_reset_state_init #(
  parameter int unsigned SETTLE_UNIT = `RSI_SETTLE_UNIT
) (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  ce,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic [31:0]                hrdata,
  output logic                       hresp,
  input  wire logic                  reset_req_pin,
  input  wire logic                  wdt_option_pin,
  output logic                       vec_rd,
  output logic [15:0]                vec_addr,
  input  wire logic [7:0]            vec_rdata,
  output logic [15:0]                pc,
  output logic                       pc_valid,
  output logic                       cpu_run,
  output logic                       ram_hold,
  output rsi_pkg::rsi_clk_cfg_t      clk_cfg,
  output rsi_pkg::rsi_port_cfg_t     port_cfg
);

  // Documented value each register takes on acknowledgment; WDT bit 7 comes from the option level
  function automatic logic [15:0] rsi_rst(input int unsigned i);
    logic [15:0] v;
    v = `RSI_RV_ZERO;
    case (i) inside
      [`RSI_IDX_PLATCH:`RSI_IDX_DIR-1]:   v = `RSI_RV_ZERO;
      [`RSI_IDX_DIR:`RSI_IDX_PULL-1]:     v = `RSI_RV_DIR;
      [`RSI_IDX_PULL:`RSI_IDX_ALT]:       v = `RSI_RV_ZERO;
      `RSI_IDX_MEMSZ:                     v = `RSI_RV_MEMSZ;
      `RSI_IDX_CLKMODE:                   v = `RSI_RV_ZERO;
      `RSI_IDX_CPUCLK:                    v = `RSI_RV_CPUCLK;
      `RSI_IDX_OSCPLL:                    v = `RSI_RV_OSCPLL;
      `RSI_IDX_MAINOSC:                   v = `RSI_RV_MAINOSC;
      [`RSI_IDX_MAINCLK:`RSI_IDX_OSCSTAT]: v = `RSI_RV_ZERO;
      `RSI_IDX_OSCSEL:                    v = `RSI_RV_OSCSEL;
      [`RSI_IDX_TXCTL:`RSI_IDX_TXCMP-1]:  v = `RSI_RV_ZERO;
      [`RSI_IDX_TXCMP:`RSI_IDX_HIZ-1]:    v = `RSI_RV_ZERO;
      [`RSI_IDX_HIZ:`RSI_IDX_EC16-1]:     v = `RSI_RV_ZERO;
      [`RSI_IDX_EC16:`RSI_IDX_EC8-1]:     v = `RSI_RV_ZERO;
      [`RSI_IDX_EC8:`RSI_IDX_IT8-1]:      v = `RSI_RV_ZERO;
      [`RSI_IDX_IT8:`RSI_IDX_WDT-1]:      v = `RSI_RV_ZERO;
      `RSI_IDX_WDT:                       v = `RSI_RV_WDT;
      default:                            v = `RSI_RV_ZERO;
    endcase
    return v;
  endfunction

  // Registers holding a full 16-bit value
  function automatic logic rsi_is16(input int unsigned i);
    return (i >= `RSI_IDX_TXCMP && i < `RSI_IDX_HIZ) ||
           (i >= `RSI_IDX_EC16 && i < `RSI_IDX_EC16CTL);
  endfunction

  // Value stored when software writes register i
  function automatic logic [15:0] rsi_wval(input int unsigned i,
                                           input logic [31:0] d);
    return rsi_is16(i) ? d[15:0] : {8'h00, d[7:0]};
  endfunction

  rsi_pkg::rsi_state_t state;
  rsi_pkg::rsi_state_t next_state;
  // Register file, one word per index below the status word
  logic [15:0]         regs [0:`RSI_NSFR-1];
  logic [15:0]         settle_cnt;
  logic [15:0]         settle_len;
  logic                req_s1;
  logic                req_s2;
  logic                opt_s1;
  logic                opt_s2;
  logic                wdt_opt;
  logic [7:0]          vec_lo_byte;
  logic                dp_act;
  logic                dp_wr;
  logic                dp_map;
  logic [6:0]          dp_idx;
  logic                wr_ok;
  logic [6:0]          ap_idx;
  logic                ap_map;
  logic                ap_take;
  logic [31:0]         rd_val;

  // Reset request synchroniser; comes up asserted so nothing runs early
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_s1 <= 1'b1;
      req_s2 <= 1'b1;
    end else if (ce) begin
      req_s1 <= reset_req_pin;
      req_s2 <= req_s1;
    end
  end

  // Option level synchroniser
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      opt_s1 <= 1'b0;
      opt_s2 <= 1'b0;
    end else if (ce) begin
      opt_s1 <= wdt_option_pin;
      opt_s2 <= opt_s1;
    end
  end

  // Settle length follows the select code held from before the reset
  always_comb begin
    settle_len = 16'(SETTLE_UNIT << regs[`RSI_IDX_OSCSEL][2:0]);
  end

  // Sequencer; a synced request parks it in hold from any step
  always_comb begin
    next_state = state;
    unique case (state)
      rsi_pkg::ST_HOLD: begin
        if (!req_s2) begin
          next_state = rsi_pkg::ST_SETTLE;
        end
      end
      rsi_pkg::ST_SETTLE: begin
        if (req_s2) begin
          next_state = rsi_pkg::ST_HOLD;
        end else if (settle_cnt >= settle_len - 16'h0001) begin
          next_state = rsi_pkg::ST_ACK;
        end
      end
      rsi_pkg::ST_ACK: begin
        next_state = req_s2 ? rsi_pkg::ST_HOLD : rsi_pkg::ST_VEC_LO;
      end
      rsi_pkg::ST_VEC_LO: begin
        next_state = req_s2 ? rsi_pkg::ST_HOLD : rsi_pkg::ST_VEC_HI;
      end
      rsi_pkg::ST_VEC_HI: begin
        next_state = req_s2 ? rsi_pkg::ST_HOLD : rsi_pkg::ST_VEC_LD;
      end
      rsi_pkg::ST_VEC_LD: begin
        next_state = req_s2 ? rsi_pkg::ST_HOLD : rsi_pkg::ST_RUN;
      end
      rsi_pkg::ST_RUN: begin
        if (req_s2) begin
          next_state = rsi_pkg::ST_HOLD;
        end
      end
      default: begin
        next_state = rsi_pkg::ST_HOLD;
      end
    endcase
  end

  // Async reset starts in settle; the request synchroniser then holds
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= rsi_pkg::ST_SETTLE;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // Settle counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settle_cnt <= 16'h0000;
    end else if (ce) begin
      if (state == rsi_pkg::ST_SETTLE && !req_s2) begin
        settle_cnt <= settle_cnt + 16'h0001;
      end else begin
        settle_cnt <= 16'h0000;
      end
    end
  end

  // Fetch strobe and address come from flops set to the next state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vec_rd   <= 1'b0;
      vec_addr <= `RSI_VEC_LO;
    end else if (ce) begin
      vec_rd   <= (next_state == rsi_pkg::ST_VEC_LO) ||
                  (next_state == rsi_pkg::ST_VEC_HI);
      vec_addr <= (next_state == rsi_pkg::ST_VEC_HI) ? `RSI_VEC_HI
                                                     : `RSI_VEC_LO;
    end
  end

  // Memory returns a byte the cycle after the request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vec_lo_byte <= 8'h00;
    end else if (ce && state == rsi_pkg::ST_VEC_HI) begin
      vec_lo_byte <= vec_rdata;
    end
  end

  // Only the program counter loses meaning while reset is in progress
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc       <= 16'h0000;
      pc_valid <= 1'b0;
    end else if (ce) begin
      if (state == rsi_pkg::ST_VEC_LD && !req_s2) begin
        pc       <= {vec_rdata, vec_lo_byte};
        pc_valid <= 1'b1;
      end else if (state != rsi_pkg::ST_RUN) begin
        pc_valid <= 1'b0;
      end
    end
  end

  // Option byte level is taken at acknowledgment, never at async reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdt_opt <= 1'b0;
    end else if (ce && state == rsi_pkg::ST_ACK) begin
      wdt_opt <= opt_s2;
    end
  end

  // Bus address phase
  always_comb begin
    ap_idx  = haddr[8:2];
    ap_map  = (haddr[31:9] == 23'h000000) &&
              (ap_idx < 7'(`RSI_NREG));
    ap_take = hsel && htrans[1] && hready && ce;
  end

  // Data phase remembers what the address phase asked for
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_act <= 1'b0;
      dp_wr  <= 1'b0;
      dp_map <= 1'b0;
      dp_idx <= 7'h00;
    end else if (ce) begin
      dp_act <= ap_take;
      dp_wr  <= ap_take && hwrite;
      dp_map <= ap_take && ap_map;
      dp_idx <= ap_idx;
    end
  end

  // Writes land only while the core runs; status words are read-only
  always_comb begin
    wr_ok = dp_act && dp_wr && dp_map &&
            (state == rsi_pkg::ST_RUN) &&
            (dp_idx < 7'(`RSI_NSFR)) &&
            (dp_idx != 7'(`RSI_IDX_OSCSTAT));
  end

  // Special-function registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < `RSI_NSFR; i++) begin
        regs[i] <= rsi_rst(i);
      end
    end else if (ce) begin
      if (state == rsi_pkg::ST_ACK) begin
        for (int i = 0; i < `RSI_NSFR; i++) begin
          regs[i] <= rsi_rst(i);
        end
        regs[`RSI_IDX_WDT][`RSI_WDT_OPT_BIT] <= opt_s2;
      end else if (wr_ok) begin
        regs[dp_idx] <= rsi_wval(int'(dp_idx), hwdata);
      end
    end
  end

  // Read value, with the word being written this cycle passed through
  always_comb begin
    rd_val = 32'h00000000;
    if (ap_map) begin
      if (ap_idx == 7'(`RSI_IDX_STAT)) begin
        rd_val[`RSI_STAT_PCV]   = pc_valid;
        rd_val[`RSI_STAT_RUN]   = (state == rsi_pkg::ST_RUN);
        rd_val[`RSI_STAT_WDOPT] = wdt_opt;
      end else if (ap_idx == 7'(`RSI_IDX_PC)) begin
        rd_val = {16'h0000, pc};
      end else if (wr_ok && dp_idx == ap_idx) begin
        rd_val = {16'h0000, rsi_wval(int'(dp_idx), hwdata)};
      end else begin
        rd_val = {16'h0000, regs[ap_idx]};
      end
    end
  end

  // Read data is captured in the address phase and stands until next read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (ce && ap_take && !hwrite) begin
      hrdata <= rd_val;
    end
  end

  // No wait states while enabled; errors are never signalled
  always_comb begin
    hreadyout = ce;
    hresp     = 1'b0;
  end

  // Run and RAM hold flags are flops tracking the next state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_run  <= 1'b0;
      ram_hold <= 1'b1;
    end else if (ce) begin
      cpu_run  <= (next_state == rsi_pkg::ST_RUN);
      ram_hold <= (next_state != rsi_pkg::ST_RUN);
    end
  end

  // Register contents to the clock logic
  always_comb begin
    clk_cfg.memory_size_select       = regs[`RSI_IDX_MEMSZ][7:0];
    clk_cfg.clk_mode                 = regs[`RSI_IDX_CLKMODE][7:0];
    clk_cfg.cpu_clk                  = regs[`RSI_IDX_CPUCLK][7:0];
    clk_cfg.internal_osc_pll_control = regs[`RSI_IDX_OSCPLL][7:0];
    clk_cfg.main_osc_control         = regs[`RSI_IDX_MAINOSC][7:0];
    clk_cfg.main_clock_mode          = regs[`RSI_IDX_MAINCLK][7:0];
    clk_cfg.osc_settle_time_select   = regs[`RSI_IDX_OSCSEL][7:0];
    clk_cfg.watchdog_enable_reg      = regs[`RSI_IDX_WDT][7:0];
  end

  // Port latch, direction and mode registers to the pad logic
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      port_cfg.latch[i] = regs[`RSI_IDX_PLATCH + i][7:0];
    end
    for (int i = 0; i < 5; i++) begin
      port_cfg.direction[i] = regs[`RSI_IDX_DIR + i][7:0];
    end
    for (int i = 0; i < 3; i++) begin
      port_cfg.pullup_enable[i] = regs[`RSI_IDX_PULL + i][7:0];
    end
    port_cfg.port6_input_mode  = regs[`RSI_IDX_P6IN][7:0];
    port_cfg.port6_output_mode = regs[`RSI_IDX_P6OUT][7:0];
    port_cfg.alt_switch        = regs[`RSI_IDX_ALT][7:0];
  end

endmodule

// File: testbench/rsi_reset_state_init_asserts.sv
`timescale 1ns/1ps
module rsi_reset_state_init_asserts (
  input wire logic                  hclk,
  input wire logic                  hresetn,
  input wire logic                  reset_req_pin,
  input wire logic                  wdt_option_pin,
  input wire logic                  vec_rd,
  input wire logic [15:0]           vec_addr,
  input wire logic [7:0]            vec_rdata,
  input wire logic [15:0]           pc,
  input wire logic                  pc_valid,
  input wire logic                  cpu_run,
  input wire logic                  ram_hold,
  input wire rsi_pkg::rsi_clk_cfg_t  clk_cfg,
  input wire rsi_pkg::rsi_port_cfg_t port_cfg
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_vec_seq;
    $rose(vec_rd) |-> vec_addr == 16'h0000 ##1
      (vec_rd && vec_addr == 16'h0001) ##1 !vec_rd;
  endproperty
  a_vec_seq: assert property (p_vec_seq)
    else $error("vector fetch order wrong");
  property p_pc_load;
    $rose(pc_valid) |-> pc == {$past(vec_rdata), $past(vec_rdata, 2)};
  endproperty
  a_pc_load: assert property (p_pc_load)
    else $error("pc not loaded from vector bytes");
  property p_run_after;
    $rose(vec_rd) |-> ##3 (cpu_run && pc_valid);
  endproperty
  a_run_after: assert property (p_run_after)
    else $error("run not entered after fetch");
  property p_ram_hold;
    ram_hold == !cpu_run;
  endproperty
  a_ram_hold: assert property (p_ram_hold)
    else $error("ram hold not tied to run");
  property p_frozen;
    !cpu_run && !$past(cpu_run) && !$rose(vec_rd) |->
      $stable(port_cfg) && $stable(clk_cfg);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("state changed during reset");
  property p_port_dflt;
    $rose(vec_rd) |-> port_cfg.latch == '0 &&
      port_cfg.direction == {5{8'hff}} && port_cfg.pullup_enable == '0 &&
      port_cfg.port6_input_mode == 8'h00 &&
      port_cfg.port6_output_mode == 8'h00 && port_cfg.alt_switch == 8'h00;
  endproperty
  a_port_dflt: assert property (p_port_dflt)
    else $error("port defaults wrong");
  property p_clk_dflt;
    $rose(vec_rd) |-> clk_cfg.memory_size_select == 8'hcf &&
      clk_cfg.clk_mode == 8'h00 && clk_cfg.cpu_clk == 8'h01 &&
      clk_cfg.internal_osc_pll_control == 8'h80 &&
      clk_cfg.main_osc_control == 8'h80 && clk_cfg.main_clock_mode == 8'h00
      && clk_cfg.osc_settle_time_select == 8'h05 &&
      clk_cfg.watchdog_enable_reg[6:0] == 7'h1a;
  endproperty
  a_clk_dflt: assert property (p_clk_dflt)
    else $error("clock defaults wrong");
  property p_wd_opt;
    $rose(vec_rd) |->
      clk_cfg.watchdog_enable_reg[7] == $past(wdt_option_pin, 3);
  endproperty
  a_wd_opt: assert property (p_wd_opt)
    else $error("watchdog option bit wrong");
  property p_pc_drop;
    $rose(reset_req_pin) |-> ##[1:5] !pc_valid;
  endproperty
  a_pc_drop: assert property (p_pc_drop)
    else $error("pc still valid in reset");

  c_fetch: cover property ($rose(vec_rd));
  c_run: cover property ($rose(cpu_run));
  c_hold: cover property (cpu_run ##1 !cpu_run);
endmodule

bind rsi_reset_state_init rsi_reset_state_init_asserts i_chk (
  .hclk(hclk), .hresetn(hresetn), .reset_req_pin(reset_req_pin),
  .wdt_option_pin(wdt_option_pin), .vec_rd(vec_rd), .vec_addr(vec_addr),
  .vec_rdata(vec_rdata), .pc(pc), .pc_valid(pc_valid), .cpu_run(cpu_run),
  .ram_hold(ram_hold), .clk_cfg(clk_cfg), .port_cfg(port_cfg));

// File: testbench/rsi_reset_state_initializer_tb.sv
`timescale 1ns/1ps
`include "rsi_defs.svh"
module rsi_reset_state_initializer_tb;
  logic                   hclk = 0, hresetn = 0, ce = 1, hsel = 0, hwrite = 0;
  logic [31:0]            haddr = '0, hwdata = '0, hrdata;
  logic [1:0]             htrans = 2'b00;
  logic [2:0]             hsize = 3'b010;
  logic                   hready, hreadyout, hresp;
  logic                   reset_req_pin = 0, wdt_option_pin = 0;
  logic                   vec_rd, pc_valid, cpu_run, ram_hold;
  logic [15:0]            vec_addr, pc;
  logic [7:0]             vec_rdata = 8'h00;
  rsi_pkg::rsi_clk_cfg_t  clk_cfg;
  rsi_pkg::rsi_port_cfg_t port_cfg;
  int                     bad_count = 0, comparisons = 0;

  assign hready = hreadyout;
  rsi_reset_state_init #(.SETTLE_UNIT(1)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .reset_req_pin(reset_req_pin), .wdt_option_pin(wdt_option_pin),
    .vec_rd(vec_rd), .vec_addr(vec_addr), .vec_rdata(vec_rdata), .pc(pc),
    .pc_valid(pc_valid), .cpu_run(cpu_run), .ram_hold(ram_hold),
    .clk_cfg(clk_cfg), .port_cfg(port_cfg));

  initial begin
    forever #4 hclk = ~hclk;
  end

  // Program memory answers one cycle after the fetch; garbage otherwise
  always @(posedge hclk) begin
    vec_rdata <= vec_rd ? (vec_addr[0] ? 8'hb7 : 8'h3c) : ~vec_rdata;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic ahb(input int idx, input logic wr, input logic [31:0] d,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= 32'(idx * 4);
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wr ? d : 32'h0;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rd_chk(input int idx, input logic [31:0] exp);
    logic [31:0] r;
    ahb(idx, 1'b0, 32'h0, r);
    chk(r, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic wr(input int idx, input logic [31:0] d);
    logic [31:0] r;
    ahb(idx, 1'b1, d, r);
  endtask

  task automatic wait_run;
    int n;
    n = 0;
    while (cpu_run !== 1'b1 && n < 800) begin
      @(posedge hclk);
      n++;
    end
    chk({31'h0, cpu_run}, 32'h1);
  endtask

  function automatic logic [31:0] dflt(input int i, input logic opt);
    if (i >= `RSI_IDX_DIR && i < `RSI_IDX_PULL) return 32'h0000_00ff;
    case (i)
      `RSI_IDX_MEMSZ:   return 32'h0000_00cf;
      `RSI_IDX_CPUCLK:  return 32'h0000_0001;
      `RSI_IDX_OSCPLL:  return 32'h0000_0080;
      `RSI_IDX_MAINOSC: return 32'h0000_0080;
      `RSI_IDX_OSCSEL:  return 32'h0000_0005;
      `RSI_IDX_WDT:     return opt ? 32'h0000_009a : 32'h0000_001a;
      default:          return 32'h0;
    endcase
  endfunction

  task automatic t_defaults(input logic opt);
    wait_run();
    chk({16'h0, pc}, 32'h0000_b73c);
    chk({31'h0, ram_hold}, 32'h0);
    chk({8'h0, port_cfg.direction[2:0]}, 32'h00ff_ffff);
    for (int i = 0; i < `RSI_IDX_MEMSZ; i++) begin
      rd_chk(i, dflt(i, opt));
    end
    rd_chk(`RSI_IDX_MEMSZ, dflt(`RSI_IDX_MEMSZ, opt));
    for (int i = `RSI_IDX_CLKMODE; i < `RSI_IDX_TXCTL; i++) begin
      rd_chk(i, dflt(i, opt));
    end
    for (int i = `RSI_IDX_TXCTL; i < `RSI_IDX_WDT; i++) begin
      rd_chk(i, dflt(i, opt));
    end
    rd_chk(`RSI_IDX_WDT, dflt(`RSI_IDX_WDT, opt));
    rd_chk(`RSI_IDX_STAT, {29'h0, opt, 2'b11});
    rd_chk(`RSI_IDX_PC, 32'h0000_b73c);
  endtask

  task automatic t_memsz;
    logic [7:0] codes [3];
    codes = '{`RSI_MEMSZ_4K, `RSI_MEMSZ_8K, `RSI_MEMSZ_16K};
    foreach (codes[k]) begin
      wr(`RSI_IDX_MEMSZ, {24'h0, codes[k]});
      rd_chk(`RSI_IDX_MEMSZ, {24'h0, codes[k]});
      chk({24'h0, clk_cfg.memory_size_select}, {24'h0, codes[k]});
    end
    wr(`RSI_IDX_OSCSTAT, 32'h0000_00ff);
    rd_chk(`RSI_IDX_OSCSTAT, 32'h0);
    wr(70, 32'h1234_5678);
    rd_chk(70, 32'h0);
    @(posedge hclk);
    ce <= 1'b0;
    @(posedge hclk);
    chk({31'h0, hreadyout}, 32'h0);
    ce <= 1'b1;
  endtask

  task automatic t_hold;
    wr(`RSI_IDX_PLATCH, 32'h0000_005a);
    wr(`RSI_IDX_DIR, 32'h0000_000f);
    wdt_option_pin <= 1'b1;
    reset_req_pin <= 1'b1;
    repeat (10) @(posedge hclk);
    chk({30'h0, pc_valid, ram_hold}, 32'h1);
    wr(`RSI_IDX_PLATCH, 32'h0000_0011);
    rd_chk(`RSI_IDX_PLATCH, 32'h0000_005a);
    chk({24'h0, port_cfg.direction[0]}, 32'h0000_000f);
    chk({24'h0, clk_cfg.memory_size_select}, {24'h0, `RSI_MEMSZ_16K});
    reset_req_pin <= 1'b0;
    t_defaults(1'b1);
  endtask

  task automatic t_async;
    wr(`RSI_IDX_MEMSZ, {24'h0, `RSI_MEMSZ_8K});
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk({24'h0, clk_cfg.memory_size_select}, 32'h0000_00cf);
    chk({30'h0, pc_valid, cpu_run}, 32'h0);
    hresetn <= 1'b1;
    t_defaults(1'b1);
  endtask

  task automatic stop_test;
    if (bad_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_defaults(1'b0);
    t_memsz();
    t_hold();
    t_async();
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge hclk);
    bad_count++;
    stop_test();
  end
endmodule
